/* rtl/pcm_call_mapper.sv */
// Packet-to-circuit call-setup mapper with AXI4-Lite registers
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "pcm_regs.svh"
module pcm_call_mapper #(
	parameter int GUARD_NS = 1000000,
	parameter int TPUT_W = 4
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Circuit side events
	input wire logic ttc_valid,
	input wire logic ttc_cli_req,
	input wire logic csn_connect,
	input wire logic csn_transit_valid,
	input wire logic [15:0] csn_transit_id,
	// Circuit side signalling
	output logic sel_valid,
	output pcm_pkg::pcm_sel_type sel_chars,
	output logic [31:0] sel_called_addr,
	output logic sel_closed_group,
	output logic sel_closed_group_oa,
	output logic cli_send,
	output logic [31:0] cli_addr,
	output logic ttd_send,
	output logic [7:0] link_cmd_addr,
	output logic [7:0] link_resp_addr,
	// Packet side signalling
	output logic clear_request,
	output logic call_connected,
	output pcm_pkg::pcm_conn_type conn_info,
	output logic [TPUT_W-1:0] conn_tput
);
	localparam int GUARD_CYCLES_RAW = (GUARD_NS + `PCM_CLK_NS - 1) / `PCM_CLK_NS;
	localparam int GUARD_CYCLES = (GUARD_CYCLES_RAW < 1) ? 1 : GUARD_CYCLES_RAW;
	localparam logic [31:0] GUARD_LAST = 32'(GUARD_CYCLES - 1);
	// ==========================================================
	// Functions
	function automatic logic [TPUT_W-1:0] cap_tput(input logic [TPUT_W-1:0] req,
		input logic [TPUT_W-1:0] rate);
		cap_tput = (req > rate) ? rate : req;
	endfunction
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		merge = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) merge[i*8 +: 8] = data[i*8 +: 8];
		end
	endfunction
	// ==========================================================
	// Register storage
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q, aw_got_q, w_got_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic [7:0] waddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [31:0] ctrl_q, util_q, calling_q, called_q, cud_q, rate_q;
	logic start_q, clr_conf_q, do_write;
	pcm_pkg::pcm_state_type state_q;
	logic [31:0] guard_q;
	logic rejected_q, fast_seen_q, teletex;
	logic [31:0] stored_calling_q;
	logic sel_valid_q, cli_send_q, ttd_send_q, clear_q, connected_q, cg_q, cgoa_q;
	pcm_pkg::pcm_sel_type sel_q;
	logic [31:0] addr_out_q, cli_addr_q;
	pcm_pkg::pcm_conn_type conn_q;
	logic [TPUT_W-1:0] tput_q;
	logic [7:0] cmd_addr_q, resp_addr_q;
	logic [TPUT_W-1:0] req_tput, csn_rate;
	assign do_write = aw_got_q && w_got_q && !bvalid_q;
	assign teletex = (cud_q[7:0] == `PCM_TELETEX);
	assign req_tput = util_q[`PCM_UTIL_TPUT_LSB +: TPUT_W];
	assign csn_rate = rate_q[TPUT_W-1:0];
	// ==========================================================
	// AXI write channels
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			waddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= `PCM_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && awready_q) begin
				awready_q <= 1'b0;
				aw_got_q <= 1'b1;
				waddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wready_q) begin
				wready_q <= 1'b0;
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				bvalid_q <= 1'b1;
				case (waddr_q)
					`PCM_OFF_CTRL, `PCM_OFF_UTIL, `PCM_OFF_CALLING, `PCM_OFF_CALLED,
					`PCM_OFF_CUD, `PCM_OFF_RATE, `PCM_OFF_STATUS, `PCM_OFF_SEL,
					`PCM_OFF_CONN, `PCM_OFF_ADDR_OUT: bresp_q <= `PCM_RESP_OKAY;
					default: bresp_q <= `PCM_RESP_SLVERR;
				endcase
			end
			if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
		end
	end
	// ==========================================================
	// Writable registers and command pulses
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= 32'h0000_0000;
			util_q <= 32'h0000_0000;
			calling_q <= 32'h0000_0000;
			called_q <= 32'h0000_0000;
			cud_q <= 32'h0000_0000;
			rate_q <= 32'h0000_0000;
			start_q <= 1'b0;
			clr_conf_q <= 1'b0;
		end else begin
			start_q <= 1'b0;
			clr_conf_q <= 1'b0;
			if (do_write) begin
				case (waddr_q)
					`PCM_OFF_CTRL: begin
						ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
						start_q <= wstrb_q[0] && wdata_q[`PCM_CTRL_START];
						clr_conf_q <= wstrb_q[0] && wdata_q[`PCM_CTRL_CLR_CONF];
					end
					`PCM_OFF_UTIL: util_q <= merge(util_q, wdata_q, wstrb_q);
					`PCM_OFF_CALLING: calling_q <= merge(calling_q, wdata_q, wstrb_q);
					`PCM_OFF_CALLED: called_q <= merge(called_q, wdata_q, wstrb_q);
					`PCM_OFF_CUD: cud_q <= merge(cud_q, wdata_q, wstrb_q);
					`PCM_OFF_RATE: rate_q <= merge(rate_q, wdata_q, wstrb_q);
					default: ;
				endcase
			end
		end
	end
	// ==========================================================
	// AXI read channel
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `PCM_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && arready_q) begin
				arready_q <= 1'b0;
				rvalid_q <= 1'b1;
				rresp_q <= `PCM_RESP_OKAY;
				case (s_axi_araddr)
					`PCM_OFF_CTRL: rdata_q <= {ctrl_q[31:4], 1'b0, ctrl_q[2:1], 1'b0};
					`PCM_OFF_UTIL: rdata_q <= util_q;
					`PCM_OFF_CALLING: rdata_q <= calling_q;
					`PCM_OFF_CALLED: rdata_q <= called_q;
					`PCM_OFF_CUD: rdata_q <= {24'h00_0000, cud_q[7:0]};
					`PCM_OFF_RATE: rdata_q <= rate_q;
					`PCM_OFF_STATUS: rdata_q <= {27'h000_0000, fast_seen_q, rejected_q, state_q};
					`PCM_OFF_SEL: rdata_q <= sel_q;
					`PCM_OFF_CONN: rdata_q <= conn_q;
					`PCM_OFF_ADDR_OUT: rdata_q <= addr_out_q;
					default: begin
						rdata_q <= 32'h0000_0000;
						rresp_q <= `PCM_RESP_SLVERR;
					end
				endcase
			end
			if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
				arready_q <= 1'b1;
			end
		end
	end
	// ==========================================================
	// Call sequencing
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= pcm_pkg::PCM_IDLE;
			guard_q <= 32'h0000_0000;
			rejected_q <= 1'b0;
			fast_seen_q <= 1'b0;
			stored_calling_q <= 32'h0000_0000;
		end else begin
			guard_q <= 32'h0000_0000;
			case (state_q)
				pcm_pkg::PCM_IDLE: begin
					if (start_q) begin
						rejected_q <= 1'b0;
						fast_seen_q <= 1'b0;
						stored_calling_q <= calling_q;
						state_q <= pcm_pkg::PCM_SELECT;
					end
				end
				pcm_pkg::PCM_SELECT: begin
					if (util_q[`PCM_UTIL_FAST]) begin
						fast_seen_q <= 1'b1;
						state_q <= pcm_pkg::PCM_CLEARING;
					end else if (!teletex && ctrl_q[`PCM_CTRL_REJECT]) begin
						rejected_q <= 1'b1;
						state_q <= pcm_pkg::PCM_CLEARING;
					end else begin
						state_q <= pcm_pkg::PCM_WAIT_TTC;
					end
				end
				pcm_pkg::PCM_WAIT_TTC: begin
					if (ttc_valid) begin
						state_q <= pcm_pkg::PCM_WAIT_CONN;
					end else if (clr_conf_q) begin
						state_q <= pcm_pkg::PCM_GUARD;
					end
				end
				pcm_pkg::PCM_WAIT_CONN: begin
					if (csn_connect) begin
						state_q <= pcm_pkg::PCM_CONNECTED;
					end else if (clr_conf_q) begin
						state_q <= pcm_pkg::PCM_GUARD;
					end
				end
				pcm_pkg::PCM_CONNECTED, pcm_pkg::PCM_CLEARING: begin
					if (clr_conf_q) begin
						state_q <= pcm_pkg::PCM_GUARD;
					end
				end
				pcm_pkg::PCM_GUARD: begin
					if (guard_q >= GUARD_LAST) begin
						state_q <= pcm_pkg::PCM_IDLE;
					end else begin
						guard_q <= guard_q + 32'h0000_0001;
					end
				end
				default: state_q <= pcm_pkg::PCM_IDLE;
			endcase
		end
	end
	// ==========================================================
	// Selection signal generation
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_valid_q <= 1'b0;
			sel_q <= '0;
			addr_out_q <= 32'h0000_0000;
			cg_q <= 1'b0;
			cgoa_q <= 1'b0;
			cmd_addr_q <= 8'h00;
			resp_addr_q <= 8'h00;
		end else begin
			sel_valid_q <= 1'b0;
			if (state_q == pcm_pkg::PCM_SELECT && !util_q[`PCM_UTIL_FAST]
				&& !(!teletex && ctrl_q[`PCM_CTRL_REJECT])) begin
				sel_valid_q <= 1'b1;
				sel_q.cot1 <= 8'h00;
				sel_q.cot1[`PCM_COT_B1] <= ctrl_q[`PCM_CTRL_STRIP];
				sel_q.cot1[`PCM_COT_ALT] <= 1'b1;
				sel_q.cot1[`PCM_COT_UC_FOLLOWS] <= 1'b1;
				sel_q.uc1 <= `PCM_UC1_FOLLOWS;
				sel_q.uc2 <= {4'h0, teletex ? `PCM_UC2_TELETEX : 4'h0};
				sel_q.cot2 <= 8'h00;
				sel_q.cot2[`PCM_COT_B3] <= util_q[`PCM_UTIL_COT2_B3];
				if (ctrl_q[`PCM_CTRL_STRIP]) begin
					addr_out_q <= {called_q[31-`PCM_NIC_BITS:0], `PCM_NIC_BITS'(0)};
				end else begin
					addr_out_q <= called_q;
				end
				cg_q <= util_q[`PCM_UTIL_CG];
				cgoa_q <= util_q[`PCM_UTIL_CGOA];
				cmd_addr_q <= `PCM_ADDR_CMD;
				resp_addr_q <= `PCM_ADDR_RESP;
			end
		end
	end
	// ==========================================================
	// Identification, clearing and connect
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cli_send_q <= 1'b0;
			ttd_send_q <= 1'b0;
			cli_addr_q <= 32'h0000_0000;
			clear_q <= 1'b0;
			connected_q <= 1'b0;
			conn_q <= '0;
			tput_q <= '0;
		end else begin
			cli_send_q <= 1'b0;
			ttd_send_q <= 1'b0;
			clear_q <= 1'b0;
			connected_q <= 1'b0;
			if (state_q == pcm_pkg::PCM_WAIT_TTC && ttc_valid) begin
				if (ttc_cli_req) begin
					cli_send_q <= 1'b1;
					cli_addr_q <= stored_calling_q;
				end else begin
					ttd_send_q <= 1'b1;
				end
			end
			if (state_q == pcm_pkg::PCM_SELECT && (util_q[`PCM_UTIL_FAST]
				|| (!teletex && ctrl_q[`PCM_CTRL_REJECT]))) begin
				clear_q <= 1'b1;
			end
			if (state_q == pcm_pkg::PCM_SELECT) begin
				tput_q <= cap_tput(req_tput, csn_rate);
			end
			if (state_q == pcm_pkg::PCM_WAIT_CONN && csn_connect) begin
				connected_q <= 1'b1;
				conn_q.window <= `PCM_WINDOW;
				conn_q.pkt_size <= `PCM_PKT_SIZE;
				conn_q.transit_id <= csn_transit_valid ? csn_transit_id : 16'h0000;
				tput_q <= cap_tput(req_tput, csn_rate);
			end
		end
	end
	// ==========================================================
	// Outputs
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign sel_valid = sel_valid_q;
	assign sel_chars = sel_q;
	assign sel_called_addr = addr_out_q;
	assign sel_closed_group = cg_q;
	assign sel_closed_group_oa = cgoa_q;
	assign cli_send = cli_send_q;
	assign cli_addr = cli_addr_q;
	assign ttd_send = ttd_send_q;
	assign link_cmd_addr = cmd_addr_q;
	assign link_resp_addr = resp_addr_q;
	assign clear_request = clear_q;
	assign call_connected = connected_q;
	assign conn_info = conn_q;
	assign conn_tput = tput_q;
endmodule
`default_nettype wire

/* shared/pcm_regs.svh */
// Register map, field positions and codes of the call-setup mapper
`ifndef PCM_REGS_SVH
`define PCM_REGS_SVH
// ==========================================================
// Byte offsets
`define PCM_OFF_CTRL 8'h00
`define PCM_OFF_UTIL 8'h04
`define PCM_OFF_CALLING 8'h08
`define PCM_OFF_CALLED 8'h0C
`define PCM_OFF_CUD 8'h10
`define PCM_OFF_RATE 8'h14
`define PCM_OFF_STATUS 8'h18
`define PCM_OFF_SEL 8'h1C
`define PCM_OFF_CONN 8'h20
`define PCM_OFF_ADDR_OUT 8'h24
// ==========================================================
// Control and utility bits
`define PCM_CTRL_START 0
`define PCM_CTRL_STRIP 1
`define PCM_CTRL_REJECT 2
`define PCM_CTRL_CLR_CONF 3
`define PCM_UTIL_FAST 0
`define PCM_UTIL_CG 1
`define PCM_UTIL_CGOA 2
`define PCM_UTIL_TRANSIT 3
`define PCM_UTIL_CALL_ID 4
`define PCM_UTIL_COT2_B3 5
`define PCM_UTIL_TPUT_LSB 8
// ==========================================================
// Character codes and constants
`define PCM_COT_B1 0
`define PCM_COT_ALT 1
`define PCM_COT_UC_FOLLOWS 2
`define PCM_COT_B3 2
`define PCM_UC1_FOLLOWS 8'h03
`define PCM_TELETEX 8'h02
`define PCM_UC2_TELETEX 4'h9
`define PCM_WINDOW 8'h02
`define PCM_PKT_SIZE 8'h80
`define PCM_NIC_BITS 16
`define PCM_ADDR_CMD 8'h03
`define PCM_ADDR_RESP 8'h01
`define PCM_CLK_NS 50
`define PCM_RESP_OKAY 2'b00
`define PCM_RESP_SLVERR 2'b10
`endif

/* shared/pcm_pkg.sv */
// Types of the call-setup mapper
`default_nettype none
package pcm_pkg;
	typedef enum logic [2:0] {
		PCM_IDLE = 3'b000,
		PCM_SELECT = 3'b001,
		PCM_WAIT_TTC = 3'b011,
		PCM_WAIT_CONN = 3'b010,
		PCM_CONNECTED = 3'b110,
		PCM_CLEARING = 3'b111,
		PCM_GUARD = 3'b101
	} pcm_state_type;
	typedef struct packed {
		logic [7:0] cot1;
		logic [7:0] uc1;
		logic [7:0] uc2;
		logic [7:0] cot2;
	} pcm_sel_type;
	typedef struct packed {
		logic [7:0] window;
		logic [7:0] pkt_size;
		logic [15:0] transit_id;
	} pcm_conn_type;
endpackage
`default_nettype wire

/* sim/pcm_call_sva.sv */
// Port assertions for the call-setup mapper
`timescale 1ns/1ps
`default_nettype none
module pcm_call_sva (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Circuit side events
	input wire logic ttc_valid,
	input wire logic ttc_cli_req,
	input wire logic csn_connect,
	input wire logic csn_transit_valid,
	input wire logic [15:0] csn_transit_id,
	// Signalling outputs
	input wire logic sel_valid,
	input wire pcm_pkg::pcm_sel_type sel_chars,
	input wire logic cli_send,
	input wire logic ttd_send,
	input wire logic [7:0] link_cmd_addr,
	input wire logic [7:0] link_resp_addr,
	input wire logic clear_request,
	input wire logic call_connected,
	input wire pcm_pkg::pcm_conn_type conn_info
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// Checks
	chk_cli_cause: assert property (cli_send |-> $past(ttc_valid && ttc_cli_req))
		else $error("cli_send without identification request");
	chk_ttd_cause: assert property (ttd_send |-> $past(ttc_valid && !ttc_cli_req))
		else $error("ttd_send without plain transit connect");
	chk_conn_transit: assert property (call_connected |-> $past(csn_connect) &&
		conn_info.transit_id == ($past(csn_transit_valid) ? $past(csn_transit_id) : 16'h0000))
		else $error("connected packet transit id wrong");
	chk_conn_fixed: assert property (call_connected |-> conn_info.window == 8'h02 &&
		conn_info.pkt_size == 8'h80)
		else $error("window or packet size wrong");
	chk_cot1_uc1: assert property (sel_valid |-> sel_chars.cot1[7:1] == 7'h03 &&
		sel_chars.uc1 == 8'h03)
		else $error("first characters wrong");
	chk_cot2_zero: assert property (sel_valid |->
		{sel_chars.cot2[3], sel_chars.cot2[1:0]} == 3'h0)
		else $error("second traffic character bits not zero");
	chk_uc2_code: assert property (sel_valid |-> sel_chars.uc2[3:0] inside {4'h9, 4'h0})
		else $error("second user class code wrong");
	chk_sel_once: assert property (sel_valid |=> !sel_valid [*8])
		else $error("selection repeated");
	chk_clear_nosel: assert property (clear_request |-> !sel_valid ##1 !sel_valid)
		else $error("selection sent with clear request");
	chk_link_addr: assert property ((cli_send || ttd_send) |-> link_cmd_addr == 8'h03 &&
		link_resp_addr == 8'h01)
		else $error("link addresses wrong");
	cover property (sel_valid);
	cover property (cli_send);
	cover property (ttd_send);
	cover property (clear_request);
endmodule
bind pcm_call_mapper pcm_call_sva pcm_call_sva_inst (.core_clk, .rst_n, .ttc_valid, .ttc_cli_req,
	.csn_connect, .csn_transit_valid, .csn_transit_id, .sel_valid, .sel_chars, .cli_send,
	.ttd_send, .link_cmd_addr, .link_resp_addr, .clear_request, .call_connected, .conn_info);
`default_nettype wire

/* sim/pcm_far_model.sv */
// Circuit-side exchange model answering selection and connect
`timescale 1ns/1ps
`default_nettype none
module pcm_far_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// From mapper
	input wire logic sel_valid,
	input wire logic cli_send,
	input wire logic ttd_send,
	// Bench settings
	input wire logic cfg_cli,
	input wire logic [3:0] cfg_delay,
	input wire logic cfg_tv,
	input wire logic [15:0] cfg_tid,
	// To mapper
	output logic ttc_valid,
	output logic ttc_cli_req,
	output logic csn_connect,
	output logic csn_transit_valid,
	output logic [15:0] csn_transit_id
);
	logic [1:0] ph_q;
	logic [3:0] cnt_q;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_q <= 2'h0;
			cnt_q <= 4'h0;
			ttc_valid <= 1'b0;
			csn_connect <= 1'b0;
		end else begin
			ttc_valid <= 1'b0;
			csn_connect <= 1'b0;
			if (sel_valid) begin
				ph_q <= 2'h1;
				cnt_q <= cfg_delay;
			end else if (cli_send || ttd_send) begin
				ph_q <= 2'h2;
				cnt_q <= cfg_delay;
			end else if (ph_q != 2'h0) begin
				if (cnt_q != 4'h0) begin
					cnt_q <= cnt_q - 4'h1;
				end else begin
					ph_q <= 2'h0;
					ttc_valid <= (ph_q == 2'h1);
					csn_connect <= (ph_q == 2'h2);
				end
			end
		end
	end
	// Qualifiers show inverse outside their pulse
	assign ttc_cli_req = ttc_valid ? cfg_cli : ~cfg_cli;
	assign csn_transit_valid = csn_connect ? cfg_tv : ~cfg_tv;
	assign csn_transit_id = csn_connect ? cfg_tid : ~cfg_tid;
endmodule
`default_nettype wire

/* sim/tb.sv */
// Self-checking bench of the call-setup mapper
`timescale 1ns/1ps
`default_nettype none
`include "pcm_regs.svh"
module tb;
	logic core_clk, rst_n;
	logic [7:0] s_axi_awaddr, s_axi_araddr, link_cmd_addr, link_resp_addr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata, sel_called_addr, cli_addr;
	logic [3:0] s_axi_wstrb, conn_tput, cfg_delay;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic ttc_valid, ttc_cli_req, csn_connect, csn_transit_valid, sel_valid, sel_closed_group;
	logic sel_closed_group_oa, cli_send, ttd_send, clear_request, call_connected, cfg_cli, cfg_tv;
	logic [15:0] csn_transit_id, cfg_tid;
	pcm_pkg::pcm_sel_type sel_chars;
	pcm_pkg::pcm_conn_type conn_info;
	logic [31:0] seed_q = 32'h0000_0002;
	logic [33:0] q_r[$];
	logic [1:0] q_b[$];
	logic [79:0] q_ev[$];
	int mismatches = 0;
	int n_tests = 0;
	localparam int GUARD_CYC = 40;
	localparam logic [33:0] OKB = 34'h0_0000_0000;
	localparam logic [33:0] SLV = 34'h2_0000_0000;
	pcm_call_mapper #(.GUARD_NS(2000)) pcm_call_mapper_inst (.core_clk, .rst_n, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ttc_valid, .ttc_cli_req,
		.csn_connect, .csn_transit_valid, .csn_transit_id, .sel_valid, .sel_chars, .sel_called_addr,
		.sel_closed_group, .sel_closed_group_oa, .cli_send, .cli_addr, .ttd_send, .link_cmd_addr,
		.link_resp_addr, .clear_request, .call_connected, .conn_info, .conn_tput);
	pcm_far_model pcm_far_model_inst (.core_clk, .rst_n, .sel_valid, .cli_send, .ttd_send,
		.cfg_cli, .cfg_delay, .cfg_tv, .cfg_tid, .ttc_valid, .ttc_cli_req, .csn_connect,
		.csn_transit_valid, .csn_transit_id);
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	// ==========================================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed_q ^= seed_q << 13;
		seed_q ^= seed_q >> 17;
		seed_q ^= seed_q << 5;
		return seed_q;
	endfunction
	function automatic logic [79:0] pk(input logic [3:0] k, input logic [31:0] a, b,
		input logic [11:0] c);
		return {k, a, b, c};
	endfunction
	function automatic logic [79:0] obs();
		if (sel_valid) return pk(4'h1, sel_chars, sel_called_addr,
			{sel_closed_group, sel_closed_group_oa, conn_tput, 6'h00});
		if (cli_send) return pk(4'h2, cli_addr, {link_cmd_addr, link_resp_addr, 16'h0000}, 12'h000);
		if (ttd_send) return pk(4'h3, 32'h0000_0000, {link_cmd_addr, link_resp_addr, 16'h0000}, 12'h000);
		if (call_connected) return pk(4'h4, conn_info, 32'h0000_0000, {conn_tput, 8'h00});
		return pk(4'h5, 32'h0000_0000, 32'h0000_0000, 12'h000);
	endfunction
	task automatic cmp_bus(input string nm, input logic [33:0] e, g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cmp_sig(input string nm, input logic [79:0] e, g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic give_verdict();
		$display("mismatches %0d n_tests %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic to_fail();
		mismatches++;
		$display("BAD wait expected done seen timeout");
		give_verdict();
	endtask
	// ==========================================================
	// Bus master and waits
	task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d,
		input logic [33:0] e);
		int n;
		if (rd) q_r.push_back(e);
		else q_b.push_back(e[33:32]);
		@(posedge core_clk);
		if (rd) begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
		end else begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
		end
		for (n = 0; n < 100; n++) begin
			@(posedge core_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) break;
		end
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
		if (n == 100) to_fail();
	endtask
	task automatic drain();
		int n;
		for (n = 0; n < 300 && q_ev.size() > 0; n++) @(posedge core_clk);
		if (q_ev.size() > 0) to_fail();
	endtask
	// ==========================================================
	// One call attempt with clearing and guard
	task automatic do_call(input logic [11:0] u, input logic [7:0] cud, input logic [3:0] rate,
		input logic strip, rej, cli, tv);
		logic [31:0] ca, cd;
		logic [3:0] cap;
		logic [1:0] f;
		ca = rnd();
		cd = rnd();
		cap = (u[11:8] > rate) ? rate : u[11:8];
		f = {u[0], !u[0] && rej && cud != 8'h02};
		cfg_cli <= cli;
		cfg_tv <= tv;
		cfg_tid <= cd[23:8];
		cfg_delay <= ca[3:0];
		bus(1'b0, `PCM_OFF_CALLING, ca, OKB);
		bus(1'b1, `PCM_OFF_CALLING, 32'h0000_0000, {2'b00, ca});
		bus(1'b0, `PCM_OFF_CALLED, cd, OKB);
		bus(1'b0, `PCM_OFF_CUD, {cd[23:0], cud}, OKB);
		bus(1'b0, `PCM_OFF_RATE, {28'h000_0000, rate}, OKB);
		bus(1'b0, `PCM_OFF_UTIL, {20'h0_0000, u}, OKB);
		if (f != 2'b00) q_ev.push_back(pk(4'h5, 32'h0000_0000, 32'h0000_0000, 12'h000));
		else begin
			q_ev.push_back(pk(4'h1, {5'h00, 2'b11, strip, 8'h03, 4'h0, (cud == 8'h02) ? 4'h9 : 4'h0,
				5'h00, u[5], 2'b00}, strip ? {cd[15:0], 16'h0000} : cd,
				{u[1], u[2], cap, 6'h00}));
			q_ev.push_back(pk(cli ? 4'h2 : 4'h3, cli ? ca : 32'h0000_0000,
				{8'h03, 8'h01, 16'h0000}, 12'h000));
			q_ev.push_back(pk(4'h4, {8'h02, 8'h80, tv ? cd[23:8] : 16'h0000},
				32'h0000_0000, {cap, 8'h00}));
		end
		bus(1'b0, `PCM_OFF_CTRL, {29'h0000_0000, rej, strip, 1'b1}, OKB);
		drain();
		bus(1'b1, `PCM_OFF_STATUS, 32'h0000_0000, {29'h0000_0000, f, (f != 2'b00) ? 3'h7 : 3'h6});
		bus(1'b0, `PCM_OFF_CTRL, 32'h0000_0008, OKB);
		bus(1'b0, `PCM_OFF_CTRL, 32'h0000_0001, OKB);
		bus(1'b1, `PCM_OFF_STATUS, 32'h0000_0000, {29'h0000_0000, f, 3'h5});
		repeat (GUARD_CYC) @(posedge core_clk);
		bus(1'b1, `PCM_OFF_STATUS, 32'h0000_0000, {29'h0000_0000, f, 3'h0});
	endtask
	// ==========================================================
	// Result watcher
	always @(posedge core_clk) begin
		if (rst_n && s_axi_bvalid && s_axi_bready)
			cmp_bus("bresp", {q_b.pop_front(), 32'h0000_0000}, {s_axi_bresp, 32'h0000_0000});
		if (rst_n && s_axi_rvalid && s_axi_rready)
			cmp_bus("rdata", q_r.pop_front(), {s_axi_rresp, s_axi_rdata});
		if (rst_n && (sel_valid || cli_send || ttd_send || call_connected || clear_request))
			cmp_sig("event", q_ev.pop_front(), obs());
	end
	// ==========================================================
	// Main sequence
	initial begin
		logic [31:0] u, r;
		rst_n = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_wstrb = 4'hf;
		{cfg_cli, cfg_tv, cfg_delay, cfg_tid} = 22'h00_0000;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		bus(1'b1, `PCM_OFF_STATUS, 32'h0000_0000, OKB);
		bus(1'b1, 8'h30, 32'h0000_0000, SLV);
		bus(1'b0, 8'h30, 32'hffff_ffff, SLV);
		bus(1'b0, `PCM_OFF_STATUS, 32'hffff_ffff, OKB);
		bus(1'b1, `PCM_OFF_STATUS, 32'h0000_0000, OKB);
		for (int i = 0; i < 8; i++) begin
			u = rnd();
			r = rnd();
			do_call({u[11:1], i == 1}, (i % 3 == 0) ? r[7:0] : 8'h02, (i == 4) ? u[11:8] : r[11:8],
				i[0], i == 3, i[1], i[2]);
		end
		give_verdict();
	end
endmodule
`default_nettype wire
